// file: verilog/scfi_pkg.sv
// constants and field layouts of the spi command decoder and fault latches
// assumes one 40 mhz core clock and a separate spi serial clock

package scfi_pkg;

  // ===================================================================
  // command word layout
  localparam int          CMD_W         = 8;
  localparam int          OPC_MSB       = 7;
  localparam int          OPC_LSB       = 5;
  localparam int          NIB_SEL_BIT   = 4;
  localparam logic [2:0]  OPC_NULL      = 3'h0;
  localparam logic [2:0]  OPC_MASK      = 3'h1;
  localparam logic [2:0]  OPC_MODE      = 3'h2;
  localparam logic [2:0]  OPC_CLEAR     = 3'h3;
  localparam logic [2:0]  OPC_DEADTIME  = 3'h4;

  // ===================================================================
  // mode and deadtime command data bits
  localparam int          MODE_LOCK_BIT = 0;
  localparam int          MODE_BOTH_BIT = 1;
  localparam int          MODE_DESAT_BIT = 3;
  localparam int          DT_CAL_BIT    = 0;

  // ===================================================================
  // status register zero bit positions
  localparam int          ST_TEMP       = 0;
  localparam int          ST_SAT        = 1;
  localparam int          ST_SUPPLY     = 2;
  localparam int          ST_CURRENT    = 3;
  localparam int          ST_PHASE      = 4;
  localparam int          ST_FRAME      = 5;
  localparam int          ST_WRITE      = 6;
  localparam int          ST_RESET      = 7;

  // ===================================================================
  // values after reset and other loaded constants
  localparam logic [7:0]  STATUS0_RESET = 8'h80;
  localparam logic [3:0]  MASK_RESET    = 4'hf;
  localparam logic [7:0]  DEADTIME_RESET = 8'hff;
  localparam logic [7:0]  DEADTIME_ZERO = 8'h00;
  localparam logic [1:0]  SEL_RESET     = 2'h0;
  localparam logic [2:0]  BITCNT_RESET  = 3'h0;
  localparam logic [2:0]  BITCNT_ONE    = 3'h1;

endpackage : scfi_pkg

// file: verilog/scfi_top.sv
// spi command decoder, fault latches and level interrupt of the pre-driver
// assumes fault inputs are pins (synchronised here), spi mode cpol 0 cpha 1
// and that the host keeps sclk still while chip select is high

`timescale 1ns/100ps
`default_nettype none

module scfi_top
  import scfi_pkg::*;
(
  input  wire logic       clk_i,            // 40 mhz time base
  input  wire logic       rstn_i,           // async reset, active low
  input  wire logic       sclk_i,           // spi clock, link domain
  input  wire logic       cs_n_i,           // chip select, active low
  input  wire logic       mosi_i,           // serial data in
  output logic            miso_o,           // serial data out
  output logic            miso_oe_o,        // miso driven while selected
  input  wire logic       over_temp_i,      // any output over temperature
  input  wire logic       sat_loss_i,       // saturation loss any output
  input  wire logic       gate_supply_low_i,// gate supply undervoltage
  input  wire logic       over_current_i,   // over-current comparator
  input  wire logic [2:0] phase_node_i,     // phase comparator outputs
  input  wire logic [2:0] drive_state_i,    // commanded high-side state
  input  wire logic       sat_blank_i,      // saturation blanking active
  input  wire logic       enabled_i,        // both enables high
  output logic            int_o,            // interrupt, active high
  output logic            both_on_mode_o,   // both-on mode selected
  output logic            desat_ignore_o,   // desat shutdown disabled
  output logic            config_lock_o,    // configuration locked
  output logic [7:0]      deadtime_o,       // deadtime in base cycles
  output logic            deadtime_cal_o    // calibration requested pulse
);

  // ===================================================================
  // link domain: shift in, count bits, shift response out
  logic                   fresh_reg;        // no sclk edge yet this frame
  logic [2:0]             bitcnt_reg;       // bits of frame, modulo eight
  logic                   frame_tog_reg;    // flips on first bit of frame
  logic [CMD_W-1:0]       rx_reg;           // last eight bits sampled
  logic [CMD_W-1:0]       tx_reg;           // outgoing shift register
  logic [CMD_W-1:0]       resp_reg;         // core-held response word

  // fresh is preset by the frame's own select so no edge is needed
  // after the frame; reset presets it too, so the first frame never
  // depends on a select edge having been seen
  always_ff @(posedge sclk_i or posedge cs_n_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fresh_reg <= 1'b1;
    else if (cs_n_i)
      fresh_reg <= 1'b1;
    else
      fresh_reg <= 1'b0;
  end

  // bit counter and response shift on the launching edge
  always_ff @(posedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bitcnt_reg    <= BITCNT_RESET;
      frame_tog_reg <= 1'b0;
      tx_reg        <= STATUS0_RESET;
    end
    else if (fresh_reg)
    begin
      // first edge: counting restarts, response word is loaded
      bitcnt_reg    <= BITCNT_ONE;
      frame_tog_reg <= ~frame_tog_reg;
      tx_reg        <= resp_reg;
    end
    else
    begin
      // later edges pass received bits on for a daisy chain
      bitcnt_reg    <= bitcnt_reg + BITCNT_ONE;
      tx_reg        <= {tx_reg[CMD_W-2:0], rx_reg[0]};
    end
  end

  // data in is sampled on the falling edge; only the last eight stay
  always_ff @(negedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rx_reg <= '0;
    else
      rx_reg <= {rx_reg[CMD_W-2:0], mosi_i};
  end

  // msb comes straight from the core word before the first edge
  assign miso_o    = fresh_reg ? resp_reg[CMD_W-1] : tx_reg[CMD_W-1];
  assign miso_oe_o = ~cs_n_i;

  // ===================================================================
  // core domain: synchronisers
  logic [2:0]             cs_sync;          // select, two stages plus edge
  logic [1:0]             tog_sync;         // frame toggle, two stages
  logic                   tog_seen_reg;     // toggle value last consumed
  logic [7:0]             flt_s1;           // fault pins, first stage
  logic [7:0]             flt_s2;           // fault pins, second stage

  // select and toggle crossings; first stages are read by stage two only
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cs_sync  <= 3'h7;
      tog_sync <= 2'h0;
    end
    else
    begin
      cs_sync  <= {cs_sync[1:0], cs_n_i};
      tog_sync <= {tog_sync[0], frame_tog_reg};
    end
  end

  // phase and drive pins go through their own two stages
  logic [2:0]             ph_s1;            // phase node, stage one
  logic [2:0]             ph_s2;            // phase node, stage two
  logic [2:0]             dr_s1;            // drive state, stage one
  logic [2:0]             dr_s2;            // drive state, stage two

  // fault and drive pins, two flip-flops each
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flt_s1 <= 8'h00;
      flt_s2 <= 8'h00;
      ph_s1  <= 3'h0;
      ph_s2  <= 3'h0;
      dr_s1  <= 3'h0;
      dr_s2  <= 3'h0;
    end
    else
    begin
      flt_s1 <= {enabled_i, sat_blank_i, 2'h0, over_current_i,
                 gate_supply_low_i, sat_loss_i, over_temp_i};
      flt_s2 <= flt_s1;
      ph_s1  <= phase_node_i;
      ph_s2  <= ph_s1;
      dr_s1  <= drive_state_i;
      dr_s2  <= dr_s1;
    end
  end

  // ===================================================================
  // frame boundaries and decode
  logic                   link_idle;        // select high, synced
  logic                   frame_end;        // select rose, synced
  logic                   got_bits;         // at least one sclk edge
  logic                   len_ok;           // count multiple of eight
  logic                   cmd_ok;           // usable command this frame
  logic [2:0]             opcode;           // command field
  logic                   locked_write;     // write refused by lock

  assign link_idle   = cs_sync[1] & cs_sync[2];
  assign frame_end   = cs_sync[1] & ~cs_sync[2];
  assign got_bits    = tog_sync[1] != tog_seen_reg;
  // rx and count are quiet once select is high, so they are read here
  assign len_ok      = bitcnt_reg == BITCNT_RESET;
  assign cmd_ok      = frame_end & got_bits & len_ok;
  assign opcode      = rx_reg[OPC_MSB:OPC_LSB];

  // the toggle marks frames with clocks, empty frames do nothing
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tog_seen_reg <= 1'b0;
    else if (frame_end)
      tog_seen_reg <= tog_sync[1];
  end

  // ===================================================================
  // configuration registers
  logic [3:0]             irq_enable_nibble_low;  // low enable nibble
  logic [3:0]             irq_enable_nibble_high; // high enable nibble
  logic                   lock_reg;         // configuration lock
  logic                   both_on_reg;      // both-on mode
  logic                   desat_reg;        // desat handling mode
  logic [7:0]             deadtime_reg;     // deadtime value
  logic                   cal_reg;          // calibration request pulse
  logic                   is_write;         // mask, mode or deadtime

  assign is_write     = (opcode == OPC_MASK) | (opcode == OPC_MODE) |
                        (opcode == OPC_DEADTIME);
  assign locked_write = cmd_ok & is_write & lock_reg;

  // enable nibbles; all sources enabled until the host says otherwise
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_enable_nibble_low  <= MASK_RESET;
      irq_enable_nibble_high <= MASK_RESET;
    end
    else if (cmd_ok && opcode == OPC_MASK && !lock_reg)
    begin
      if (rx_reg[NIB_SEL_BIT])
        irq_enable_nibble_high <= rx_reg[3:0];
      else
        irq_enable_nibble_low  <= rx_reg[3:0];
    end
  end

  // mode bits; the lock may be set in the same word and never drops
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lock_reg    <= 1'b0;
      both_on_reg <= 1'b0;
      desat_reg   <= 1'b0;
    end
    else if (cmd_ok && opcode == OPC_MODE && !lock_reg)
    begin
      lock_reg    <= rx_reg[MODE_LOCK_BIT];
      both_on_reg <= rx_reg[MODE_BOTH_BIT];
      desat_reg   <= rx_reg[MODE_DESAT_BIT];
    end
  end

  // deadtime: zero form loads zero, calibrate form only flags a request;
  // the pulse measurement itself lives outside this block
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      deadtime_reg <= DEADTIME_RESET;
      cal_reg      <= 1'b0;
    end
    else
    begin
      cal_reg <= 1'b0;
      if (cmd_ok && opcode == OPC_DEADTIME && !lock_reg)
      begin
        if (rx_reg[DT_CAL_BIT])
          cal_reg      <= 1'b1;
        else
          deadtime_reg <= DEADTIME_ZERO;
      end
    end
  end

  // ===================================================================
  // fault latches, status register zero
  logic [7:0]             status0_reg;      // latched flags
  logic [7:0]             reported_reg;     // flags as of frame start
  logic [7:0]             fault_evt;        // flags raised this cycle
  logic [7:0]             clr_mask;         // flags cleared this cycle
  logic [7:0]             enable_all;       // both nibbles together
  logic                   phase_err;        // gated phase error

  assign phase_err = |(ph_s2 ^ dr_s2) & ~flt_s2[6] & ~both_on_reg;

  // bit order follows the enable nibbles, so one mask serves both
  assign fault_evt = {~flt_s2[7],
                      locked_write,
                      frame_end & got_bits & ~len_ok,
                      phase_err,
                      flt_s2[3:0]};
  assign enable_all = {irq_enable_nibble_high, irq_enable_nibble_low};

  // only flags seen set at frame start may clear, and only on a good word
  always_comb
  begin
    clr_mask = 8'h00;
    if (cmd_ok && opcode == OPC_CLEAR)
    begin
      if (rx_reg[NIB_SEL_BIT])
        clr_mask = {rx_reg[3:0], 4'h0};
      else
        clr_mask = {4'h0, rx_reg[3:0]};
      clr_mask = clr_mask & reported_reg;
    end
  end

  // snapshot of register zero as this frame starts; it freezes
  // on the same edge as the reply word, so both hold the same flags when the reply is register zero
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      reported_reg <= 8'h00;
    else if (link_idle)
      reported_reg <= status0_reg;
  end

  // new events win over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      status0_reg <= STATUS0_RESET;
    else
      status0_reg <= (status0_reg & ~clr_mask) | fault_evt;
  end

  // level interrupt from a flip-flop
  logic                   int_reg;          // registered interrupt
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      int_reg <= 1'b0;
    else
      int_reg <= |(status0_reg & enable_all);
  end

  // ===================================================================
  // response selection
  logic [1:0]             sel_reg;          // register for next reply

  // only a status read steers the next reply away from register zero
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sel_reg <= SEL_RESET;
    else if (cmd_ok)
    begin
      if (opcode == OPC_NULL)
        sel_reg <= rx_reg[1:0];
      else
        sel_reg <= SEL_RESET;
    end
  end

  // reply is refreshed only while idle so the link sees a still word
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      resp_reg <= STATUS0_RESET;
    else if (link_idle)
    begin
      case (sel_reg)
        2'h1:    resp_reg <= {4'h0, desat_reg, 1'b0, both_on_reg, lock_reg};
        2'h2:    resp_reg <= enable_all;
        2'h3:    resp_reg <= deadtime_reg;
        default: resp_reg <= status0_reg;
      endcase
    end
  end

  assign int_o          = int_reg;
  assign both_on_mode_o = both_on_reg;
  assign desat_ignore_o = desat_reg;
  assign config_lock_o  = lock_reg;
  assign deadtime_o     = deadtime_reg;
  assign deadtime_cal_o = cal_reg;

  // ===================================================================
  // assertions
  a_null_keeps_state: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cmd_ok && opcode == OPC_NULL |=>
      $stable(enable_all) && ((~status0_reg & $past(status0_reg)) == 8'h00))
    else $error("status read changed a latch or mask");

  a_frame_err_flag: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    frame_end && got_bits && !len_ok |=> status0_reg[ST_FRAME] ##1
      $stable(enable_all))
    else $error("bad length did not raise framing flag");

  a_clear_needs_ok: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    frame_end && !len_ok |=> (~status0_reg & $past(status0_reg)) == 8'h00)
    else $error("latch cleared by a bad frame");

  a_clear_at_end: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (~status0_reg & $past(status0_reg)) != 8'h00 |->
      $past(frame_end) && $past(opcode) == OPC_CLEAR)
    else $error("latch cleared outside a clear frame end");

  a_lock_refuses: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cmd_ok && is_write && lock_reg |=>
      status0_reg[ST_WRITE] && $stable(enable_all) && $stable(deadtime_reg))
    else $error("locked write not refused");

  a_lock_sticky: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    lock_reg |=> lock_reg [*4])
    else $error("configuration lock dropped");

  a_fault_holds: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    fault_evt[ST_TEMP] |=> status0_reg[ST_TEMP] ##1
      (!enable_all[ST_TEMP] || int_o))
    else $error("present fault not latched");

  a_int_level: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    |(status0_reg & enable_all) |=> int_o)
    else $error("interrupt low with enabled flag");

  a_disable_event: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !flt_s2[7] |=> status0_reg[ST_RESET])
    else $error("disable did not set reset event");

  a_reply_select: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cmd_ok && opcode == OPC_NULL |=> sel_reg == $past(rx_reg[1:0]))
    else $error("status read selected the wrong register");

endmodule : scfi_top

`default_nettype wire

// file: verif/scfi_host.sv
// spi host model: the master side of the command link
// assumes spi mode cpol 0 cpha 1 and the core clock for idle spacing
`timescale 1ns/100ps
`default_nettype none

module scfi_host (
  input  wire logic clk_i,     // core clock, paces idle time
  input  wire logic miso_i,    // serial reply
  input  wire logic miso_oe_i, // reply driven
  output var  logic sclk_o,    // link clock, still outside frames
  output var  logic cs_n_o,    // chip select, active low
  output var  logic mosi_o     // serial command
);
  // ===================================================================
  // idle levels
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // ===================================================================
  // one frame of n bits, msb first; reply taken before each fall
  task automatic xfer(input logic [15:0] d, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk_i);
    #1.3 cs_n_o = 1'b0;
    // the reply word is frozen only after the select is synced
    repeat (4) @(posedge clk_i);
    #2.1;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk_o = 1'b1;
      mosi_o = d[i];
      #3;
      r = {r[14:0], miso_oe_i ? miso_i : 1'bx};
      sclk_o = 1'b0;
      #3;
    end
    cs_n_o = 1'b1;
    // released line must not keep showing the last bit
    mosi_o = ~mosi_o;
    // idle spacing plus the latency of the command's effect
    repeat (8) @(posedge clk_i);
  endtask : xfer
endmodule : scfi_host
`default_nettype wire

// file: verif/spi_command_fault_irq_tb.sv
// self-checking bench of the command decoder and fault latches
// assumes scfi_host drives the link; faults driven on the core clock
`timescale 1ns/100ps
`default_nettype none

module spi_command_fault_irq_tb;
  import scfi_pkg::*;
  logic        clk_i, rstn_i, sclk, cs_n, mosi, miso, miso_oe;
  logic        ot, sat, vlow, oc, blank, en, int_q, both, dsi, lock, cal;
  logic [2:0]  pn, ds;
  logic [7:0]  dt;
  logic [15:0] r;
  int          mismatches, cmp_count, cycles, cal_cnt;

  // ===================================================================
  // clock, design and host
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  scfi_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .over_temp_i(ot), .sat_loss_i(sat), .gate_supply_low_i(vlow),
    .over_current_i(oc), .phase_node_i(pn), .drive_state_i(ds),
    .sat_blank_i(blank), .enabled_i(en), .int_o(int_q),
    .both_on_mode_o(both), .desat_ignore_o(dsi), .config_lock_o(lock),
    .deadtime_o(dt), .deadtime_cal_o(cal));

  scfi_host host (.clk_i(clk_i), .miso_i(miso), .miso_oe_i(miso_oe),
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  // ===================================================================
  // hang guard and calibration pulse count
  always @(posedge clk_i)
  begin
    cycles++;
    if (cal)
      cal_cnt++;
    if (cycles == 5000)
    begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude;
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one 8-bit command; reply lands in r
  task automatic cmd(input logic [7:0] c);
    host.xfer({8'h00, c}, 8, r);
  endtask : cmd

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  // ===================================================================
  // scenarios
  task automatic t_reset;
    wt(4);
    chk("int", 8'h01, {7'h00, int_q});
    cmd(8'h00);
    chk("first reply", 8'h80, r[7:0]);
    chk("deadtime", 8'hff, dt);
  endtask : t_reset

  task automatic t_select;
    cmd(8'h1d);
    cmd(8'h02);
    chk("reg1", 8'h00, r[7:0]);
    cmd(8'h03);
    chk("reg2", 8'hff, r[7:0]);
    cmd(8'h00);
    chk("reg3", 8'hff, r[7:0]);
    cmd(8'h00);
    chk("reg0", 8'h80, r[7:0]);
  endtask : t_select

  task automatic t_faults;
    cmd(8'h78);
    chk("int", 8'h00, {7'h00, int_q});
    ot <= 1'b1;
    sat <= 1'b1;
    vlow <= 1'b1;
    oc <= 1'b1;
    wt(4);
    {ot, vlow, oc} <= 3'h0;
    wt(4);
    chk("int", 8'h01, {7'h00, int_q});
    cmd(8'h00);
    chk("reg0", 8'h0f, r[7:0]);
    cmd(8'h6f);
    chk("int", 8'h01, {7'h00, int_q});
    cmd(8'h00);
    chk("reg0", 8'h02, r[7:0]);
    cmd(8'h2d);
    chk("int", 8'h00, {7'h00, int_q});
    sat <= 1'b0;
    cmd(8'h62);
    cmd(8'h2f);
    ds <= 3'h1;
    blank <= 1'b1;
    cmd(8'h00);
    chk("reg0", 8'h00, r[7:0]);
    blank <= 1'b0;
    wt(4);
    cmd(8'h00);
    chk("reg0", 8'h10, r[7:0]);
    pn <= 3'h1;
    cmd(8'h71);
    // a fault rising during the clear frame must survive it
    fork
      cmd(8'h61);
      begin
        wt(3);
        ot <= 1'b1;
        wt(2);
        ot <= 1'b0;
      end
    join
    cmd(8'h00);
    chk("reg0", 8'h01, r[7:0]);
    cmd(8'h61);
  endtask : t_faults

  task automatic t_frame;
    host.xfer(16'h007f, 7, r);
    cmd(8'h00);
    chk("reg0", 8'h20, r[7:0]);
    // a latched flag that the clear in a bad-length frame must not touch
    ot <= 1'b1;
    wt(4);
    ot <= 1'b0;
    host.xfer(16'h0061, 12, r);
    cmd(8'h00);
    chk("reg0", 8'h21, r[7:0]);
    host.xfer(16'ha572, 16, r);
    chk("chain", 8'h21, r[15:8]);
    chk("chain", 8'ha5, r[7:0]);
    cmd(8'h00);
    chk("reg0", 8'h01, r[7:0]);
    cmd(8'h61);
  endtask : t_frame

  task automatic t_lock;
    int n;
    cmd(8'h80);
    chk("deadtime", 8'h00, dt);
    n = cal_cnt;
    cmd(8'h81);
    chk("cal", 8'h01, 8'(cal_cnt - n));
    cmd(8'h4b);
    chk("mode", 8'h07, {5'h00, dsi, both, lock});
    ds <= 3'h5;
    cmd(8'h01);
    cmd(8'h20);
    chk("reg1", 8'h0b, r[7:0]);
    cmd(8'h02);
    chk("reg0", 8'h40, r[7:0]);
    cmd(8'h00);
    chk("reg2", 8'hff, r[7:0]);
    chk("int", 8'h01, {7'h00, int_q});
  endtask : t_lock

  task automatic t_rerun;
    ds <= 3'h1;
    en <= 1'b0;
    wt(4);
    en <= 1'b1;
    cmd(8'h00);
    chk("reg0", 8'hc0, r[7:0]);
    rstn_i <= 1'b0;
    wt(4);
    rstn_i <= 1'b1;
    wt(4);
    chk("mode", 8'h00, {5'h00, dsi, both, lock});
    cmd(8'h01);
    cmd(8'h02);
    chk("reg1", 8'h00, r[7:0]);
    cmd(8'h00);
    chk("reg2", 8'hff, r[7:0]);
  endtask : t_rerun

  // ===================================================================
  // main sequence
  initial
  begin
    rstn_i <= 1'b0;
    {ot, sat, vlow, oc, blank} <= 5'h00;
    en <= 1'b1;
    pn <= 3'h0;
    ds <= 3'h0;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    cal_cnt = 0;
    wt(4);
    rstn_i <= 1'b1;
    t_reset();
    t_select();
    t_faults();
    t_frame();
    t_lock();
    t_rerun();
    conclude();
  end
endmodule : spi_command_fault_irq_tb
`default_nettype wire
